/* File: fpcs_frac_fb.v */
/*
  Fractional-N feedback divider: divides the oscillator by N or N+1, chosen
  each feedback cycle by the carry of a fraction accumulator.
  Assumes run, n and k are steady while running; N below 1 acts as 1.
*/
`timescale 1ns/1ps
`include "fpcs_regs.vh"
module fpcs_frac_fb (
  // Clock and reset
  input  wire                    clk,
  input  wire                    rst_n,
  // Control
  input  wire                    run,
  input  wire                    fractional_enable,
  input  wire [3:0]              n_ratio,
  input  wire [`FPCS_FRAC_W-1:0] k_ratio,
  // Feedback pulse
  output reg                     fb_tick
);
  reg  [`FPCS_FRAC_W-1:0] acc;
  reg  [4:0]              cnt;
  wire [3:0]              n_eff = (n_ratio == 4'h0) ? 4'h1 : n_ratio;
  // Fraction ignored when disabled, giving pure integer-N
  wire [`FPCS_FRAC_W-1:0] k_eff = fractional_enable ? k_ratio : {`FPCS_FRAC_W{1'b0}};
  wire [`FPCS_FRAC_W:0]   next_acc = {1'b0, acc} + {1'b0, k_eff};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc     <= {`FPCS_FRAC_W{1'b0}};
      cnt     <= 5'h00;
      fb_tick <= 1'b0;
    end else if (!run) begin
      acc     <= {`FPCS_FRAC_W{1'b0}};
      cnt     <= 5'h00;
      fb_tick <= 1'b0;
    end else if (cnt == 5'h00) begin
      fb_tick <= 1'b1;
      acc     <= next_acc[`FPCS_FRAC_W-1:0];
      // Carry stretches this cycle to N+1 oscillator periods
      cnt     <= next_acc[`FPCS_FRAC_W] ? {1'b0, n_eff} : {1'b0, n_eff} - 5'h01;
    end else begin
      fb_tick <= 1'b0;
      cnt     <= cnt - 5'h01;
    end
  end
endmodule

/* File: fpcs_ref_src.sv */
/* Reference clock source model for the PLL input pin.
   Assumes the bench sets period_ns before raising run. */
`timescale 1ns/1ps
module fpcs_ref_src (
  // Control
  input wire  run,
  input real  period_ns,
  // Clock out
  output reg  ref_clk
);
  initial ref_clk = 1'b0;
  // Stands low while stopped, like a gated oscillator
  always begin
    if (run) begin
      #(period_ns / 2.0) ref_clk = ~ref_clk;
    end else begin
      ref_clk = 1'b0;
      @(run);
    end
  end
endmodule

/* File: fpcs_regs.vh */
/*
  Register offsets, field positions, reset values and timing counts for the
  fractional PLL clock setup block.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef FPCS_REGS_VH
`define FPCS_REGS_VH

// Control word addresses (7-bit register index)
`define FPCS_ADDR_W            7
`define FPCS_DATA_W            9
`define FPCS_OFF_POWER_MGMT    7'h01
`define FPCS_OFF_PLL_INT_CTRL  7'h24
`define FPCS_OFF_PLL_FRAC_HI   7'h25
`define FPCS_OFF_PLL_FRAC_MID  7'h26
`define FPCS_OFF_PLL_FRAC_LO   7'h27

// Reset values
`define FPCS_RST_POWER_MGMT    9'h000
`define FPCS_RST_PLL_INT_CTRL  9'h048
`define FPCS_RST_PLL_FRAC_HI   9'h00C
`define FPCS_RST_PLL_FRAC_MID  9'h093
`define FPCS_RST_PLL_FRAC_LO   9'h0E9

// power_management_one fields
`define FPCS_PLL_ENABLE_BIT    5
`define FPCS_VREF_SEL_HI       1
`define FPCS_VREF_SEL_LO       0

// pll_integer_and_control fields
`define FPCS_PLL_POWER_OFF_BIT 7
`define FPCS_FRAC_ENABLE_BIT   6
`define FPCS_PRESCALE_HI       5
`define FPCS_PRESCALE_LO       4
`define FPCS_INT_RATIO_HI      3
`define FPCS_INT_RATIO_LO      0

// Fraction assembly
`define FPCS_FRAC_W            24
`define FPCS_FRAC_HI_W         6
`define FPCS_FRAC_PART_W       9

// Prescale codes
`define FPCS_PRE_DOUBLE        2'h0
`define FPCS_PRE_PASS          2'h1
`define FPCS_PRE_HALF          2'h2
`define FPCS_PRE_QUARTER       2'h3

// Fixed divide after the PLL, in half steps (divide by 4)
`define FPCS_FIXED_DIV_HALF    6'h08

// Lock detector: tolerated tick imbalance and saturation
`define FPCS_LOCK_WINDOW       8'h02
`define FPCS_ERR_SAT           8'h7F

`endif

/* File: fpcs_tick_div.v */
/*
  Tick-rate divider counting in half steps, so ratios such as 1.5 come out
  as an alternating 1/2 tick spacing.
  Assumes in_tick is a one-cycle pulse on clk; half_ratio below 2 acts as 2.
*/
`timescale 1ns/1ps
module fpcs_tick_div #(
  parameter W = 6
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // Ratio and input ticks
  input  wire         in_tick,
  input  wire [W-1:0] half_ratio,
  // Divided output
  output reg          out_tick,
  output reg          out_level
);
  reg  [W-1:0] acc;
  wire [W:0]   sum   = {1'b0, acc} + {{W{1'b0}}, 1'b0} + {{(W-1){1'b0}}, 2'h2};
  wire [W:0]   ratio = (half_ratio < {{(W-2){1'b0}}, 2'h2}) ? {{(W-1){1'b0}}, 2'h2} : {1'b0, half_ratio};
  wire [W:0]   diff  = sum - ratio;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc       <= {W{1'b0}};
      out_tick  <= 1'b0;
      out_level <= 1'b0;
    end else begin
      out_tick <= 1'b0;
      if (in_tick) begin
        if (sum >= ratio) begin
          acc       <= diff[W-1:0];
          out_tick  <= 1'b1;
          out_level <= ~out_level;
        end else begin
          acc <= sum[W-1:0];
        end
      end
    end
  end
endmodule

/* File: fpcs_top.v */
/*
  Fractional PLL clock setup: control registers, reference prescaler,
  fractional-N feedback divider, lock monitor, fixed divide by 4, clock
  source select, system clock post-divider and general-purpose clock out.
  Assumes clk stands in for the PLL oscillator, ref_clk_pin is an
  asynchronous reference well below clk/4, and control words arrive as
  single-cycle write strobes on clk.
*/
`timescale 1ns/1ps
`include "fpcs_regs.vh"
module fpcs_top (
  // Clock and reset
  input  wire                     clk,
  input  wire                     rst_n,
  // Control word port
  input  wire                     ctl_write,
  input  wire [`FPCS_ADDR_W-1:0]  ctl_addr,
  input  wire [`FPCS_DATA_W-1:0]  ctl_wdata,
  output reg  [`FPCS_DATA_W-1:0]  ctl_rdata,
  // Loose clock controls
  input  wire                     clock_source_select,
  input  wire [2:0]               system_clock_postdivider,
  input  wire [1:0]               output_clock_divider,
  input  wire                     gp_clock_select,
  // Reference clock pin
  input  wire                     ref_clk_pin,
  // Clock outputs and status
  output wire                     pll_active,
  output reg                      pll_locked,
  output wire                     system_clock_tick,
  output wire                     system_clock,
  output reg                      gp_pin_out,
  output reg                      gp_pin_oe
);
  // Registers
  reg [`FPCS_DATA_W-1:0] power_management_one;
  reg [`FPCS_DATA_W-1:0] pll_integer_and_control;
  reg [`FPCS_DATA_W-1:0] pll_fraction_high;
  reg [`FPCS_DATA_W-1:0] pll_fraction_middle;
  reg [`FPCS_DATA_W-1:0] pll_fraction_low;

  // Field views
  wire       pll_enable_bit           = power_management_one[`FPCS_PLL_ENABLE_BIT];
  wire [1:0] reference_voltage_select = power_management_one[`FPCS_VREF_SEL_HI:`FPCS_VREF_SEL_LO];
  wire       pll_power_off_bit        = pll_integer_and_control[`FPCS_PLL_POWER_OFF_BIT];
  wire       fractional_enable_bit    = pll_integer_and_control[`FPCS_FRAC_ENABLE_BIT];
  wire [1:0] input_prescale_field     = pll_integer_and_control[`FPCS_PRESCALE_HI:`FPCS_PRESCALE_LO];
  wire [3:0] integer_ratio_field      = pll_integer_and_control[`FPCS_INT_RATIO_HI:`FPCS_INT_RATIO_LO];
  wire [`FPCS_FRAC_W-1:0] fractional_ratio_field = {
    pll_fraction_high[`FPCS_FRAC_HI_W-1:0],
    pll_fraction_middle[`FPCS_FRAC_PART_W-1:0],
    pll_fraction_low[`FPCS_FRAC_PART_W-1:0]};

  // Register writes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_management_one    <= `FPCS_RST_POWER_MGMT;
      pll_integer_and_control <= `FPCS_RST_PLL_INT_CTRL;
      pll_fraction_high       <= `FPCS_RST_PLL_FRAC_HI;
      pll_fraction_middle     <= `FPCS_RST_PLL_FRAC_MID;
      pll_fraction_low        <= `FPCS_RST_PLL_FRAC_LO;
    end else if (ctl_write) begin
      case (ctl_addr)
        `FPCS_OFF_POWER_MGMT: begin
          power_management_one <= ctl_wdata;
        end
        `FPCS_OFF_PLL_INT_CTRL: begin
          pll_integer_and_control <= ctl_wdata;
        end
        `FPCS_OFF_PLL_FRAC_HI: begin
          // Upper bits of the high part do not exist
          pll_fraction_high <= {3'h0, ctl_wdata[`FPCS_FRAC_HI_W-1:0]};
        end
        `FPCS_OFF_PLL_FRAC_MID: begin
          pll_fraction_middle <= ctl_wdata;
        end
        `FPCS_OFF_PLL_FRAC_LO: begin
          pll_fraction_low <= ctl_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Registered readback; unmapped addresses read zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_rdata <= {`FPCS_DATA_W{1'b0}};
    end else begin
      case (ctl_addr)
        `FPCS_OFF_POWER_MGMT:   ctl_rdata <= power_management_one;
        `FPCS_OFF_PLL_INT_CTRL: ctl_rdata <= pll_integer_and_control;
        `FPCS_OFF_PLL_FRAC_HI:  ctl_rdata <= pll_fraction_high;
        `FPCS_OFF_PLL_FRAC_MID: ctl_rdata <= pll_fraction_middle;
        `FPCS_OFF_PLL_FRAC_LO:  ctl_rdata <= pll_fraction_low;
        default:                ctl_rdata <= {`FPCS_DATA_W{1'b0}};
      endcase
    end
  end

  // Run gating
  assign pll_active = pll_enable_bit
                    & (reference_voltage_select != 2'h0)
                    & ~pll_power_off_bit;

  // Reference pin synchroniser
  reg ref_meta;
  reg ref_sync;
  reg ref_prev;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
      ref_prev <= 1'b0;
    end else begin
      ref_meta <= ref_clk_pin;
      ref_sync <= ref_meta;
      ref_prev <= ref_sync;
    end
  end
  wire ref_rise = ref_sync & ~ref_prev;
  wire ref_fall = ~ref_sync & ref_prev;

  // Input prescaler
  reg [1:0] pre_cnt;
  reg       pre_tick;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt  <= 2'h0;
      pre_tick <= 1'b0;
    end else begin
      pre_tick <= 1'b0;
      case (input_prescale_field)
        `FPCS_PRE_DOUBLE: begin
          // Both edges count, doubling the reference rate
          pre_tick <= ref_rise | ref_fall;
        end
        `FPCS_PRE_PASS: begin
          pre_tick <= ref_rise;
        end
        `FPCS_PRE_HALF: begin
          if (ref_rise) begin
            pre_cnt  <= {1'b0, ~pre_cnt[0]};
            pre_tick <= pre_cnt[0];
          end
        end
        default: begin
          if (ref_rise) begin
            pre_cnt  <= pre_cnt + 2'h1;
            pre_tick <= (pre_cnt == 2'h3);
          end
        end
      endcase
    end
  end

  // Fractional-N feedback path
  wire fb_tick;
  fpcs_frac_fb u_frac_fb (
    .clk     (clk),
    .rst_n   (rst_n),
    .run     (pll_active),
    .fractional_enable (fractional_enable_bit),
    .n_ratio (integer_ratio_field),
    .k_ratio (fractional_ratio_field),
    .fb_tick (fb_tick)
  );

  // Lock monitor: balance of reference against feedback ticks
  reg signed [7:0] tick_err;
  reg        [3:0] agree_cnt;
  // Offset is cumulative: after a rate slip it stays outside the window
  // until the PLL is stopped and restarted, traded for a small detector
  wire       [7:0] neg_err = 8'h00 - tick_err;
  wire       [7:0] err_mag = tick_err[7] ? neg_err : tick_err;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_err   <= 8'h00;
      agree_cnt  <= 4'h0;
      pll_locked <= 1'b0;
    end else if (!pll_active) begin
      tick_err   <= 8'h00;
      agree_cnt  <= 4'h0;
      pll_locked <= 1'b0;
    end else begin
      // Saturates so a dead reference cannot wrap back into the window
      if (pre_tick & ~fb_tick && tick_err != 8'sh7F) begin
        tick_err <= tick_err + 8'sh01;
      end else if (fb_tick & ~pre_tick && tick_err != -8'sh7F) begin
        tick_err <= tick_err - 8'sh01;
      end
      // Lock asserts after fifteen in-window reference ticks
      if (pre_tick) begin
        if (err_mag <= `FPCS_LOCK_WINDOW) begin
          if (agree_cnt != 4'hF) begin
            agree_cnt <= agree_cnt + 4'h1;
          end
        end else begin
          agree_cnt <= 4'h0;
        end
      end
      pll_locked <= (agree_cnt == 4'hF) && (err_mag <= `FPCS_LOCK_WINDOW);
    end
  end

  // PLL output ticks: oscillator stands in, only while running
  wire pll_tick = pll_active;

  // Fixed divide by 4
  wire div4_tick;
  fpcs_tick_div #(
    .W (6)
  ) u_div4 (
    .clk        (clk),
    .rst_n      (rst_n),
    .in_tick    (pll_tick),
    .half_ratio (`FPCS_FIXED_DIV_HALF),
    .out_tick   (div4_tick),
    .out_level  ()
  );

  // Source select ahead of the post-divider
  wire src_tick = clock_source_select ? div4_tick : ref_rise;

  // Post-divider ratio in half steps
  reg [5:0] post_half;
  always @* begin
    case (system_clock_postdivider)
      3'h0:    post_half = 6'h02;
      3'h1:    post_half = 6'h03;
      3'h2:    post_half = 6'h04;
      3'h3:    post_half = 6'h06;
      3'h4:    post_half = 6'h08;
      3'h5:    post_half = 6'h0C;
      3'h6:    post_half = 6'h10;
      default: post_half = 6'h18;
    endcase
  end

  fpcs_tick_div #(
    .W (6)
  ) u_postdiv (
    .clk        (clk),
    .rst_n      (rst_n),
    .in_tick    (src_tick),
    .half_ratio (post_half),
    .out_tick   (system_clock_tick),
    .out_level  (system_clock)
  );

  // General-purpose pin clock divider
  // Fed from the PLL side only, so the pin stops while the PLL is off
  reg [5:0] gp_half;
  always @* begin
    case (output_clock_divider)
      2'h0:    gp_half = 6'h02;
      2'h1:    gp_half = 6'h04;
      2'h2:    gp_half = 6'h06;
      default: gp_half = 6'h08;
    endcase
  end

  wire gp_level;
  fpcs_tick_div #(
    .W (6)
  ) u_gpdiv (
    .clk        (clk),
    .rst_n      (rst_n),
    .in_tick    (div4_tick),
    .half_ratio (gp_half),
    .out_tick   (),
    .out_level  (gp_level)
  );

  // Pin drive; held low and undriven unless selected
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gp_pin_out <= 1'b0;
      gp_pin_oe  <= 1'b0;
    end else begin
      gp_pin_oe  <= gp_clock_select;
      gp_pin_out <= gp_clock_select & gp_level;
    end
  end
endmodule

/* File: fpcs_top_asserts.sv */
/* Assertions on fpcs_top ports: PLL gating, system clock pacing, pin, readback.
   Assumes it is bound to fpcs_top and that fpcs_regs.vh is on the include path. */
`timescale 1ns/1ps
`include "fpcs_regs.vh"
module fpcs_top_asserts (
  // Clock, reset and control port
  input wire       clk,
  input wire       rst_n,
  input wire       ctl_write,
  input wire [6:0] ctl_addr,
  input wire [8:0] ctl_wdata,
  input wire [8:0] ctl_rdata,
  // Clock controls
  input wire       clock_source_select,
  input wire [2:0] system_clock_postdivider,
  input wire       gp_clock_select,
  // Outputs
  input wire       pll_active,
  input wire       system_clock_tick,
  input wire       system_clock,
  input wire       gp_pin_out,
  input wire       gp_pin_oe
);
  reg  [8:0] pm, ic, kh, km, kl, exp_rd;
  wire       go = clock_source_select && system_clock_postdivider == 3'h0 && pll_active;

  // Shadow of the register file, rebuilt from the write strobes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pm <= `FPCS_RST_POWER_MGMT;
      ic <= `FPCS_RST_PLL_INT_CTRL;
      kh <= `FPCS_RST_PLL_FRAC_HI;
      km <= `FPCS_RST_PLL_FRAC_MID;
      kl <= `FPCS_RST_PLL_FRAC_LO;
    end else if (ctl_write) begin
      case (ctl_addr)
        `FPCS_OFF_POWER_MGMT:   pm <= ctl_wdata;
        `FPCS_OFF_PLL_INT_CTRL: ic <= ctl_wdata;
        `FPCS_OFF_PLL_FRAC_HI:  kh <= {3'h0, ctl_wdata[5:0]};
        `FPCS_OFF_PLL_FRAC_MID: km <= ctl_wdata;
        `FPCS_OFF_PLL_FRAC_LO:  kl <= ctl_wdata;
        default: ;
      endcase
    end
  end

  always @* begin
    case (ctl_addr)
      `FPCS_OFF_POWER_MGMT:   exp_rd = pm;
      `FPCS_OFF_PLL_INT_CTRL: exp_rd = ic;
      `FPCS_OFF_PLL_FRAC_HI:  exp_rd = kh;
      `FPCS_OFF_PLL_FRAC_MID: exp_rd = km;
      `FPCS_OFF_PLL_FRAC_LO:  exp_rd = kl;
      default:                exp_rd = 9'h000;
    endcase
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_pll_gate: assert property (pll_active == (pm[5] && pm[1:0] != 2'h0 && !ic[7]))
    else $error("pll_active does not follow enable, vref select and power-off");
  a_rdata_map: assert property ($past(rst_n) |-> ctl_rdata == $past(exp_rd))
    else $error("readback differs from register contents");
  a_tick_single: assert property (system_clock_tick |=> !system_clock_tick)
    else $error("system clock tick wider than one cycle");
  a_system_clock_toggle: assert property (system_clock_tick |-> ##[0:1] $changed(system_clock))
    else $error("system clock did not toggle on its tick");
  a_div4_spacing: assert property (go ##1 (go && system_clock_tick) ##1 go [*4] |->
      system_clock_tick && !$past(system_clock_tick, 2) && !$past(system_clock_tick, 3))
    else $error("undivided PLL ticks not spaced by four");
  a_off_silent: assert property ((clock_source_select && !pll_active) [*4] |-> !system_clock_tick)
    else $error("system clock ticks while PLL is off");
  a_pin_idle: assert property (!gp_clock_select |=> !gp_pin_oe && !gp_pin_out)
    else $error("pin driven while not selected");
  a_pin_drive: assert property (gp_clock_select |=> gp_pin_oe)
    else $error("pin not driven while selected");
endmodule

bind fpcs_top fpcs_top_asserts u_chk (
  .clk(clk), .rst_n(rst_n), .ctl_write(ctl_write), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata),
  .ctl_rdata(ctl_rdata), .clock_source_select(clock_source_select),
  .system_clock_postdivider(system_clock_postdivider), .gp_clock_select(gp_clock_select),
  .pll_active(pll_active), .system_clock_tick(system_clock_tick), .system_clock(system_clock),
  .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe)
);

/* File: fpcs_top_tb_top.sv */
/* Self-checking bench for fpcs_top: registers, gating, dividers, pin, lock.
   Assumes fpcs_ref_src feeds the reference pin and a 200 MHz clk. */
`timescale 1ns/1ps
`include "fpcs_regs.vh"
module fpcs_top_tb_top;
  reg        clk, rst_n, ctl_write, clock_source_select, gp_clock_select, ref_run;
  reg  [6:0] ctl_addr;
  reg  [8:0] ctl_wdata;
  reg  [2:0] system_clock_postdivider;
  reg  [1:0] output_clock_divider;
  real       ref_period;
  wire [8:0] ctl_rdata;
  wire       ref_clk_pin, pll_active, pll_locked, system_clock_tick, system_clock, gp_pin_out, gp_pin_oe;
  integer    errors, cmp_count, cycles, n, i;
  integer    hr [0:7];

  fpcs_top dut (
    .clk(clk), .rst_n(rst_n), .ctl_write(ctl_write), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata),
    .ctl_rdata(ctl_rdata), .clock_source_select(clock_source_select),
    .system_clock_postdivider(system_clock_postdivider), .output_clock_divider(output_clock_divider),
    .gp_clock_select(gp_clock_select), .ref_clk_pin(ref_clk_pin), .pll_active(pll_active),
    .pll_locked(pll_locked), .system_clock_tick(system_clock_tick), .system_clock(system_clock),
    .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe)
  );
  fpcs_ref_src ref_src (.run(ref_run), .period_ns(ref_period), .ref_clk(ref_clk_pin));

  task report_and_stop;
    begin
      if (errors == 0 && cmp_count > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  task cmp9(input string what, input [8:0] exp, input [8:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("Error %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task cmp_cnt(input string what, input integer exp, input integer got);
    begin
      cmp_count = cmp_count + 1;
      if (got != exp) begin
        errors = errors + 1;
        $display("Error %s expected %0d seen %0d", what, exp, got);
      end
    end
  endtask

  task wr(input [6:0] a, input [8:0] d);
    begin
      @(posedge clk);
      ctl_write <= 1'b1;
      ctl_addr <= a;
      ctl_wdata <= d;
      @(posedge clk);
      ctl_write <= 1'b0;
    end
  endtask

  task rd(input [6:0] a, input [8:0] exp);
    begin
      @(posedge clk);
      ctl_addr <= a;
      repeat (2) @(posedge clk);
      #1 cmp9("ctl_rdata", exp, ctl_rdata);
    end
  endtask

  // For system ticks (not pin edges), syncs to a tick first so the window holds whole periods
  task count(input integer m, input sel, output integer c);
    reg prev;
    begin
      c = 0;
      prev = gp_pin_out;
      for (n = 0; n < 200 && !sel && system_clock_tick !== 1'b1; n = n + 1)
        @(posedge clk) #1;
      repeat (m) begin
        @(posedge clk) #1 c = c + (sel ? (gp_pin_out === 1'b1 && prev === 1'b0) : (system_clock_tick === 1'b1));
        prev = gp_pin_out;
      end
    end
  endtask

  task t_regs;
    begin
      rd(`FPCS_OFF_POWER_MGMT, 9'h000);
      rd(`FPCS_OFF_PLL_INT_CTRL, 9'h048);
      rd(`FPCS_OFF_PLL_FRAC_HI, 9'h00C);
      rd(`FPCS_OFF_PLL_FRAC_MID, 9'h093);
      rd(`FPCS_OFF_PLL_FRAC_LO, 9'h0E9);
      wr(`FPCS_OFF_PLL_FRAC_HI, 9'h1FF);
      wr(7'h7F, 9'h1FF);
      rd(`FPCS_OFF_PLL_FRAC_HI, 9'h03F);
      rd(7'h7F, 9'h000);
    end
  endtask

  task t_enable;
    integer c;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        wr(`FPCS_OFF_POWER_MGMT, {3'h0, i[2], 3'h0, i[1:0]});
        #1 cmp9("pll_active", {8'h00, i[2] && i[1:0] != 2'h0}, {8'h00, pll_active});
      end
      wr(`FPCS_OFF_PLL_INT_CTRL, 9'h0C8);
      #1 cmp9("pll_active", 9'h000, {8'h00, pll_active});
      count(100, 1'b0, c);
      cmp_cnt("ticks while off", 0, c);
      wr(`FPCS_OFF_PLL_INT_CTRL, 9'h048);
    end
  endtask

  task t_postdiv;
    integer c;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        system_clock_postdivider <= i[2:0];
        repeat (60) @(posedge clk);
        #1 count(384, 1'b0, c);
        cmp_cnt("system ticks", 192 / hr[i], c);
      end
      system_clock_postdivider <= 3'h0;
    end
  endtask

  task t_ref_source;
    integer c;
    begin
      clock_source_select <= 1'b0;
      ref_period = 40.3;
      ref_run <= 1'b1;
      repeat (20) @(posedge clk);
      #1 count(806, 1'b0, c);
      cmp_cnt("reference ticks in range", 1, c >= 99 && c <= 101);
      clock_source_select <= 1'b1;
    end
  endtask

  task t_gp_pin;
    integer c, c0;
    begin
      gp_clock_select <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        output_clock_divider <= i[1:0];
        repeat (40) @(posedge clk);
        #1 count(480, 1'b1, c);
        if (i == 0)
          c0 = c;
        cmp_cnt("pin edges scaled", 1, c > 0 && c * (i + 1) >= c0 - 2 * (i + 1) && c * (i + 1) <= c0 + 2 * (i + 1));
        cmp9("gp_pin_oe", 9'h001, {8'h00, gp_pin_oe});
      end
      gp_clock_select <= 1'b0;
      repeat (3) @(posedge clk);
      #1 cmp9("gp pin idle", 9'h000, {7'h00, gp_pin_oe, gp_pin_out});
    end
  endtask

  task wait_lock(input exp);
    begin
      for (n = 0; n < 4000 && pll_locked !== exp; n = n + 1)
        @(posedge clk) #1;
      cmp9("pll_locked", {8'h00, exp}, {8'h00, pll_locked});
    end
  endtask

  // Off-rate reference first, so each lock is earned afresh
  task lock_case(input [8:0] ctl, input [5:0] khi, input real per);
    begin
      wr(`FPCS_OFF_PLL_INT_CTRL, ctl);
      wr(`FPCS_OFF_PLL_FRAC_HI, {3'h0, khi});
      ref_period = per * 1.3;
      wait_lock(1'b0);
      ref_period = per;
      // Tick offset is cumulative, so restart the PLL once the rate matches
      wr(`FPCS_OFF_POWER_MGMT, 9'h000);
      repeat (30) @(posedge clk);
      wr(`FPCS_OFF_POWER_MGMT, 9'h023);
      wait_lock(1'b1);
    end
  endtask

  task t_lock;
    begin
      wr(`FPCS_OFF_PLL_FRAC_MID, 9'h000);
      wr(`FPCS_OFF_PLL_FRAC_LO, 9'h000);
      lock_case(9'h018, 6'h00, 40.0);
      lock_case(9'h008, 6'h00, 80.0);
      lock_case(9'h02C, 6'h00, 30.0);
      lock_case(9'h057, 6'h20, 37.5);
      wr(`FPCS_OFF_PLL_INT_CTRL, 9'h017);
      wait_lock(1'b0);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end

  initial begin
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    hr = '{2, 3, 4, 6, 8, 12, 16, 24};
    rst_n = 1'b0;
    ctl_write = 1'b0;
    ctl_addr = 7'h00;
    ctl_wdata = 9'h000;
    clock_source_select = 1'b1;
    system_clock_postdivider = 3'h0;
    output_clock_divider = 2'h0;
    gp_clock_select = 1'b0;
    ref_run = 1'b0;
    ref_period = 40.0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_enable;
    t_postdiv;
    t_ref_source;
    t_gp_pin;
    t_lock;
    report_and_stop;
  end
endmodule
